//--- hdl/uart_defs.svh
// Constants of the serial port control and status block
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------------
`define ADDR_SERIAL_PORT_CONTROL  8'h98
`define ADDR_SERIAL_DATA_BUFFER   8'h99
`define RST_SERIAL_PORT_CONTROL   8'h40
`define RST_SERIAL_DATA_BUFFER    8'h00

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define BIT_FRAME_WIDTH_SELECT    7
`define BIT_RESERVED              6
`define BIT_MULTIDROP_CHECK       5
`define BIT_RX_ENABLE             4
`define BIT_TX_NINTH              3
`define BIT_RX_NINTH              2
`define BIT_TX_DONE               1
`define BIT_RX_DONE               0

// ----------------------------------------------------------------------
// Serial timing
// ----------------------------------------------------------------------
`define TICKS_PER_BIT             2
`define SAMPLE_TICK               1
`define DATA_BITS                 8

`endif

//--- hdl/uart_pkg.sv
// Types shared by the serial port control and status block
package uart_pkg;

   // Transmitter states, one-hot
   typedef enum logic [4:0] {
      TX_IDLE  = 5'b0_0001,
      TX_START = 5'b0_0010,
      TX_DATA  = 5'b0_0100,
      TX_NINTH = 5'b0_1000,
      TX_STOP  = 5'b1_0000
   } tx_state_t;

   // Receiver states, one-hot
   typedef enum logic [4:0] {
      RX_IDLE  = 5'b0_0001,
      RX_START = 5'b0_0010,
      RX_DATA  = 5'b0_0100,
      RX_NINTH = 5'b0_1000,
      RX_STOP  = 5'b1_0000
   } rx_state_t;

endpackage : uart_pkg

//--- hdl/uart_tx.sv
// Serial transmitter with start, data, optional ninth and stop bits
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"

module uart_tx (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       resetn_in,
   // Control
   input  wire logic       baud_tick_in,
   input  wire logic       start_in,
   input  wire logic [7:0] data_in,
   input  wire logic       nine_bit_in,
   input  wire logic       ninth_in,
   // Status and line
   output logic            done_out,
   output logic            busy_out,
   output logic            txd_out
);
   import uart_pkg::*;

   typedef struct packed {
      uart_pkg::tx_state_t state;
      logic [7:0]          shift;
      logic                ninth;
      logic [2:0]          bit_cnt;
      logic                tick_cnt;
      logic                txd;
      logic                done;
   } tx_regs_t;

   tx_regs_t r;
   tx_regs_t next_r;

   // Bit end after the second overflow pulse
   logic bit_end;
   assign bit_end = baud_tick_in && (r.tick_cnt == 1'(`TICKS_PER_BIT - 1));

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      if (baud_tick_in) begin
         next_r.tick_cnt = r.tick_cnt + 1'b1;
      end
      case (r.state)
         TX_IDLE: begin
            next_r.txd = 1'b1;
            if (start_in) begin
               next_r.shift    = data_in;
               next_r.ninth    = ninth_in;
               next_r.state    = TX_START;
               next_r.tick_cnt = 1'b0;
               next_r.txd      = 1'b0;
            end
         end
         TX_START: begin
            if (bit_end) begin
               next_r.state   = TX_DATA;
               next_r.bit_cnt = 3'd0;
               next_r.txd     = r.shift[0];
            end
         end
         TX_DATA: begin
            if (bit_end) begin
               next_r.shift   = {1'b1, r.shift[7:1]};
               next_r.bit_cnt = r.bit_cnt + 3'd1;
               if (r.bit_cnt == 3'(`DATA_BITS - 1)) begin
                  next_r.done = 1'b1;
                  if (nine_bit_in) begin
                     next_r.state = TX_NINTH;
                     next_r.txd   = r.ninth;
                     next_r.done  = 1'b0;
                  end else begin
                     next_r.state = TX_STOP;
                     next_r.txd   = 1'b1;
                  end
               end else begin
                  next_r.txd = r.shift[1];
               end
            end
         end
         TX_NINTH: begin
            if (bit_end) begin
               next_r.done  = 1'b1;
               next_r.state = TX_STOP;
               next_r.txd   = 1'b1;
            end
         end
         TX_STOP: begin
            if (bit_end) begin
               next_r.state = TX_IDLE;
            end
         end
         default: begin
            next_r.state = TX_IDLE;
         end
      endcase
   end

   // Register the state
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r <= '{state: TX_IDLE, shift: 8'h00, ninth: 1'b0, bit_cnt: 3'd0,
                tick_cnt: 1'b0, txd: 1'b1, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign done_out = r.done;
   assign busy_out = (r.state != TX_IDLE);
   assign txd_out  = r.txd;

endmodule : uart_tx
`default_nettype wire

//--- hdl/uart_rx.sv
// Serial receiver sampling each bit on its second timer overflow pulse, at the end of the bit
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"

module uart_rx (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       resetn_in,
   // Control
   input  wire logic       baud_tick_in,
   input  wire logic       enable_in,
   input  wire logic       nine_bit_in,
   input  wire logic       rxd_in,
   // Received frame
   output logic            frame_out,
   output logic [7:0]      data_out,
   output logic            ninth_out
);
   import uart_pkg::*;

   typedef struct packed {
      uart_pkg::rx_state_t state;
      logic [7:0]          shift;
      logic                ninth;
      logic [2:0]          bit_cnt;
      logic                tick_cnt;
      logic                frame;
   } rx_regs_t;

   rx_regs_t r;
   rx_regs_t next_r;

   // Sample point is the second pulse of each bit
   logic sample;
   assign sample = baud_tick_in && (r.tick_cnt == 1'(`SAMPLE_TICK));

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_r       = r;
      next_r.frame = 1'b0;
      if (baud_tick_in) begin
         next_r.tick_cnt = r.tick_cnt + 1'b1;
      end
      case (r.state)
         RX_IDLE: begin
            next_r.tick_cnt = 1'b0;
            if (enable_in && !rxd_in) begin
               next_r.state = RX_START;
            end
         end
         RX_START: begin
            // A high start sample is a glitch, go back to hunting
            if (sample) begin
               next_r.state   = rxd_in ? RX_IDLE : RX_DATA;
               next_r.bit_cnt = 3'd0;
            end
         end
         RX_DATA: begin
            if (sample) begin
               next_r.shift   = {rxd_in, r.shift[7:1]};
               next_r.bit_cnt = r.bit_cnt + 3'd1;
               if (r.bit_cnt == 3'(`DATA_BITS - 1)) begin
                  next_r.state = nine_bit_in ? RX_NINTH : RX_STOP;
               end
            end
         end
         RX_NINTH: begin
            if (sample) begin
               next_r.ninth = rxd_in;
               next_r.state = RX_STOP;
            end
         end
         RX_STOP: begin
            if (sample) begin
               if (!nine_bit_in) begin
                  next_r.ninth = rxd_in;
               end
               next_r.frame = 1'b1;
               next_r.state = RX_IDLE;
            end
         end
         default: begin
            next_r.state = RX_IDLE;
         end
      endcase
      // Dropping the enable abandons a frame in flight
      if (!enable_in) begin
         next_r.state = RX_IDLE;
      end
   end

   // Register the state
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r <= '{state: RX_IDLE, shift: 8'h00, ninth: 1'b0, bit_cnt: 3'd0,
                tick_cnt: 1'b0, frame: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign frame_out = r.frame;
   assign data_out  = r.shift;
   assign ninth_out = r.ninth;

endmodule : uart_rx
`default_nettype wire

//--- hdl/uart_control_status.sv
// Serial port control and status registers with transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"

module uart_control_status (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       resetn_in,
   // Special register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   // Baud and interrupt
   input  wire logic       baud_tick_in,
   input  wire logic       irq_enable_in,
   output logic            irq_out,
   // Serial line
   input  wire logic       rxd_in,
   output logic            txd_out
);
   import uart_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] rx_latch;
      logic [7:0] rdata;
      logic       irq;
      logic       txd;
   } top_regs_t;

   top_regs_t r;
   top_regs_t next_r;

   logic       tx_done;
   logic       tx_busy;
   logic       tx_line;
   logic       rx_frame;
   logic [7:0] rx_data;
   logic       rx_ninth;
   logic       wr_ctrl;
   logic       wr_data;
   logic       accept;

   assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_SERIAL_PORT_CONTROL);
   assign wr_data = reg_wr_in && (reg_addr_in == `ADDR_SERIAL_DATA_BUFFER);

   // ----------------------------------------------------------------------
   // Transmitter and receiver
   // ----------------------------------------------------------------------
   // data write loads shifter
   // A write while a frame is going out is dropped: the shifter is busy
   uart_tx u_tx (
      .clk_sys_in   (clk_sys_in),
      .resetn_in    (resetn_in),
      .baud_tick_in (baud_tick_in),
      .start_in     (wr_data && !tx_busy),
      .data_in      (reg_wdata_in),
      .nine_bit_in  (r.control[`BIT_FRAME_WIDTH_SELECT]),
      .ninth_in     (r.control[`BIT_TX_NINTH]),
      .done_out     (tx_done),
      .busy_out     (tx_busy),
      .txd_out      (tx_line)
   );

   uart_rx u_rx (
      .clk_sys_in   (clk_sys_in),
      .resetn_in    (resetn_in),
      .baud_tick_in (baud_tick_in),
      .enable_in    (r.control[`BIT_RX_ENABLE]),
      .nine_bit_in  (r.control[`BIT_FRAME_WIDTH_SELECT]),
      .rxd_in       (rxd_in),
      .frame_out    (rx_frame),
      .data_out     (rx_data),
      .ninth_out    (rx_ninth)
   );

   // Acceptance of a received frame
   always_comb begin
      accept = rx_frame && !r.control[`BIT_RX_DONE];
      if (r.control[`BIT_MULTIDROP_CHECK] && !rx_ninth) begin
         accept = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   always_comb begin
      next_r = r;
      // Software writes the control bits; reserved bit is read-only
      if (wr_ctrl) begin
         next_r.control = reg_wdata_in;
         next_r.control[`BIT_RESERVED] = r.control[`BIT_RESERVED];
      end
      // hardware sets tx done
      // Set wins over a software clear in the same cycle
      if (tx_done) begin
         next_r.control[`BIT_TX_DONE] = 1'b1;
      end
      if (accept) begin
         next_r.rx_latch = rx_data;
         next_r.control[`BIT_RX_NINTH] = rx_ninth;
         next_r.control[`BIT_RX_DONE]  = 1'b1;
      end
      // Read data is registered; the control port samples it next cycle
      case (reg_addr_in)
         `ADDR_SERIAL_PORT_CONTROL: next_r.rdata = r.control;
         `ADDR_SERIAL_DATA_BUFFER:  next_r.rdata = r.rx_latch;
         default:                   next_r.rdata = 8'h00;
      endcase
      if (!reg_rd_in) begin
         next_r.rdata = r.rdata;
      end
      next_r.irq = irq_enable_in &&
                   (next_r.control[`BIT_TX_DONE] || next_r.control[`BIT_RX_DONE]);
      next_r.txd = tx_line;
   end

   // Register the state
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         r <= '{control: `RST_SERIAL_PORT_CONTROL, rx_latch: `RST_SERIAL_DATA_BUFFER,
                rdata: 8'h00, irq: 1'b0, txd: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_out = r.rdata;
   assign irq_out       = r.irq;
   assign txd_out       = r.txd;

endmodule : uart_control_status
`default_nettype wire

//--- tb/uart_control_status_properties.sv
// Port checker of the serial port control and status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"

module uart_control_status_properties (
   // Clock and reset
   input wire logic       clk_sys_in,
   input wire logic       resetn_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   // Baud, interrupt and line
   input wire logic       baud_tick_in,
   input wire logic       irq_enable_in,
   input wire logic       irq_out,
   input wire logic       rxd_in,
   input wire logic       txd_out
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   logic [4:0] low_ticks;
   logic       unmapped;
   logic       ctrl_rd;

   // Ticks seen while the line is low; an all-zero nine-bit frame is the longest run
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_ticks <= 5'h00;
      end else if (txd_out) begin
         low_ticks <= 5'h00;
      end else if (baud_tick_in) begin
         low_ticks <= low_ticks + 5'h01;
      end
   end

   // Address decode seen from outside
   assign ctrl_rd  = reg_rd_in && (reg_addr_in == `ADDR_SERIAL_PORT_CONTROL);
   assign unmapped = (reg_addr_in != `ADDR_SERIAL_PORT_CONTROL) &&
                     (reg_addr_in != `ADDR_SERIAL_DATA_BUFFER);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_reset_idle: assert property ($rose(resetn_in) |-> txd_out && !irq_out)
      else $error("line or interrupt not idle after reset");
   a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   a_reserved_one: assert property (ctrl_rd |=> reg_rdata_out[6])
      else $error("reserved control bit read as zero");
   a_unmapped_zero: assert property (reg_rd_in && unmapped |=> reg_rdata_out == 8'h00)
      else $error("unmapped read returned data");
   a_irq_enable: assert property ($rose(irq_out) |-> $past(irq_enable_in))
      else $error("interrupt raised while disabled");
   a_irq_masked: assert property (!irq_enable_in |=> !irq_out)
      else $error("interrupt stays up while disabled");
   // A write in the sampling cycle may clear the flags at that same edge
   a_irq_sticky: assert property (irq_out && irq_enable_in && !reg_wr_in |=> irq_out)
      else $error("done flag dropped without a write");
   a_low_bound: assert property (low_ticks <= 5'h14)
      else $error("line held low beyond a frame");

   // Main scenarios reached
   c_tx_frame: cover property ($fell(txd_out));
   c_irq_up: cover property ($rose(irq_out));
   c_ctrl_read: cover property (ctrl_rd);
endmodule : uart_control_status_properties

bind uart_control_status uart_control_status_properties u_uart_control_status_properties (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .baud_tick_in(baud_tick_in), .irq_enable_in(irq_enable_in),
   .irq_out(irq_out), .rxd_in(rxd_in), .txd_out(txd_out)
);
`default_nettype wire

//--- tb/remote_serial_node.sv
// Behavioural model of the remote serial node on the far end of the line
`timescale 1ns/1ps
`default_nettype none

module remote_serial_node (
   // Clock and timing
   input  wire logic        clk_sys_in,
   input  wire logic        baud_tick_in,
   // Frame setting
   input  wire logic        nine_bit_in,
   // Serial lines
   input  wire logic        txd_in,
   output var  logic        rxd_out,
   // Captured frame, start bit in bit 0
   output var  logic [10:0] frame_out,
   output var  logic [7:0]  frames_out
);
   logic [10:0] cap;

   // Line idles high, as with a pull-up
   initial begin
      rxd_out    = 1'b1;
      frame_out  = 11'h000;
      frames_out = 8'h00;
   end

   task automatic tick_wait(input int n);
      repeat (n) begin
         @(posedge clk_sys_in);
         // Pulse seen as the design sees it, before this edge updates it
         while (!baud_tick_in) @(posedge clk_sys_in);
      end
   endtask : tick_wait

   // start, data LSB first, last bit, stop; in eight-bit mode the last bit is sent in the stop bit's place
   task automatic send(input logic [7:0] d, input logic nine, input logic last);
      logic [10:0] bits;
      bits = {1'b1, last, d, 1'b0};
      tick_wait(1);
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         rxd_out <= bits[i];
         tick_wait(2);
      end
      rxd_out <= 1'b1;
   endtask : send

   always begin
      @(negedge txd_in);
      cap = 11'h000;
      for (int i = 0; i < (nine_bit_in ? 11 : 10); i++) begin
         tick_wait((i == 0) ? 1 : 2);
         cap[i] = txd_in;
      end
      frame_out  <= cap;
      frames_out <= frames_out + 8'h01;
   end
endmodule : remote_serial_node
`default_nettype wire

//--- tb/uart_control_status_test.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.svh"

module uart_control_status_test;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clk_sys_in = 1'b0;
   logic        resetn_in, reg_wr_in, reg_rd_in, baud_tick_in, irq_enable_in;
   logic        irq_out, rxd_in, txd_out, node_nine, nine, tb8, acc, rb8;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, rd, d, last_d, frames;
   logic [10:0] frame;
   logic [4:0]  c;
   logic [1:0]  tick_cnt = 2'h0;
   int          failures, n_tests, seed;
   // Receive cases: frame width, multidrop check, enable, last bit, keep flag
   logic [4:0]  rx_cases [9] = '{5'h06, 5'h04, 5'h0c, 5'h0e, 5'h1c, 5'h1e, 5'h14, 5'h17, 5'h02};

   uart_control_status u_uart_control_status (
      .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .baud_tick_in(baud_tick_in),
      .irq_enable_in(irq_enable_in), .irq_out(irq_out), .rxd_in(rxd_in), .txd_out(txd_out));

   remote_serial_node u_remote_serial_node (
      .clk_sys_in(clk_sys_in), .baud_tick_in(baud_tick_in), .nine_bit_in(node_nine),
      .txd_in(txd_out), .rxd_out(rxd_in), .frame_out(frame), .frames_out(frames));

   // Clock, and a timer overflow every fourth cycle
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      tick_cnt     <= tick_cnt + 2'h1;
      baud_tick_in <= (tick_cnt == 2'h3);
   end

   // ----------------------------------------
   // Tasks and expectations
   // ----------------------------------------
   task automatic tally_and_finish();
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in    <= 1'b0;
   endtask : reg_write

   // Read data is registered at the same edge that takes the strobe
   task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in   <= 1'b0;
      #1 v = reg_rdata_out;
   endtask : reg_read

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : settle

   // Bounded wait for the node to finish capturing a frame
   task automatic wait_frame(input logic [7:0] n0);
      for (int k = 0; k < 400 && frames == n0; k++) @(posedge clk_sys_in);
      if (frames == n0) begin
         failures++;
         tally_and_finish();
      end
      #1;
   endtask : wait_frame

   function automatic logic [10:0] exp_frame(input logic [7:0] v, input logic n9, input logic b8);
      return n9 ? {1'b1, b8, v, 1'b0} : {2'b01, v, 1'b0};
   endfunction : exp_frame

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      irq_enable_in = 1'b1;
      node_nine = 1'b0;
      failures = 0;
      n_tests = 0;
      seed = 32'h6152_a229;
      rb8 = 1'b0;
      last_d = 8'h00;
      repeat (8) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      // Reset values, read-only reserved bit, unmapped place
      reg_read(`ADDR_SERIAL_PORT_CONTROL, rd);
      check("control reset", 11'h040, rd);
      reg_read(`ADDR_SERIAL_DATA_BUFFER, rd);
      check("data reset", 11'h000, rd);
      reg_write(`ADDR_SERIAL_PORT_CONTROL, 8'h00);
      reg_write(8'h9a, 8'hff);
      reg_read(`ADDR_SERIAL_PORT_CONTROL, rd);
      check("reserved bit", 11'h040, rd);
      reg_read(8'h9a, rd);
      check("unmapped read", 11'h000, rd);
      // Transmit in both widths; the ninth bit set in eight-bit mode must not show
      for (int i = 0; i < 4; i++) begin
         nine = i[0];
         tb8 = (i < 2) ? 1'b1 : 1'($random(seed));
         d = 8'($random(seed));
         node_nine <= nine;
         reg_write(`ADDR_SERIAL_PORT_CONTROL, {nine, 1'b1, 2'b00, tb8, 3'h0});
         settle(2);
         check("irq after clear", 11'h000, irq_out);
         irq_enable_in <= (i != 2);
         reg_write(`ADDR_SERIAL_DATA_BUFFER, d);
         wait_frame(frames);
         check("tx frame", exp_frame(d, nine, tb8), frame);
         check("irq at stop", (i != 2), irq_out);
         reg_read(`ADDR_SERIAL_PORT_CONTROL, rd);
         check("tx done", {nine, 1'b1, 2'b00, tb8, 3'b010}, rd);
         irq_enable_in <= 1'b1;
         settle(2);
         check("irq enabled", 11'h001, irq_out);
      end
      // Receive cases, each twice with random data
      for (int j = 0; j < 18; j++) begin
         c = rx_cases[j % 9];
         d = 8'($random(seed));
         reg_write(`ADDR_SERIAL_PORT_CONTROL, {c[4], 1'b1, c[3], c[2], 1'b0, rb8, 1'b0, c[0]});
         u_remote_serial_node.send(d, c[4], c[1]);
         // Flag lands one cycle after the stop sample
         settle(4);
         acc = c[2] && !c[0] && (!c[3] || c[1]);
         if (acc) begin
            rb8 = c[1];
            last_d = d;
         end
         reg_read(`ADDR_SERIAL_PORT_CONTROL, rd);
         check("rx control", {c[4], 1'b1, c[3], c[2], 1'b0, rb8, 1'b0, acc | c[0]}, rd);
         check("rx irq", acc | c[0], irq_out);
         reg_read(`ADDR_SERIAL_DATA_BUFFER, rd);
         check("rx latch", last_d, rd);
      end
      tally_and_finish();
   end

   // Cuts a hang short
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      failures++;
      tally_and_finish();
   end
endmodule : uart_control_status_test
`default_nettype wire
